// *** lgcd_clock_gate.sv ***
// Internal clock gate and clock output pin driver
`default_nettype none
module lgcd_clock_gate (
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // Controls
    input  wire logic osc_in,
    input  wire logic disp_on,
    input  wire logic pump_on,
    input  wire logic temp_meas_on,
    input  wire logic clock_output_enable,
    input  wire logic clk_pin_is_output,
    // Outputs
    output logic      int_clk_run,
    output logic      clk_pin_out,
    output logic      clk_pin_oe
);
    logic run_d, run_q, pin_d, pin_q, oe_d, oe_q;

    // --------------------------------------------------------------
    // Next state
    // --------------------------------------------------------------
    always_comb begin
        run_d = disp_on | pump_on | temp_meas_on;
        oe_d  = clock_output_enable & clk_pin_is_output;
        pin_d = oe_d & run_d & osc_in;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            run_q <= 1'b0;
            pin_q <= 1'b0;
            oe_q  <= 1'b0;
        end else begin
            run_q <= run_d;
            pin_q <= pin_d;
            oe_q  <= oe_d;
        end
    end

    assign int_clk_run = run_q;
    assign clk_pin_out = pin_q;
    assign clk_pin_oe  = oe_q;
endmodule : lgcd_clock_gate
`default_nettype wire

// *** lgcd_decoder.sv ***
// General command decoder with staged settings, calibration reload and clock control
`default_nettype none
// Operation
// - A write of 0x00 with select 00 commits the staged settings to the live ones.
// - A write of 0x01 with select 00 returns every setting to its default.
// - A write of 0x1f with select 00 clears the reset status flag.
// - Chip reset and calibration reload both copy the calibration cells into registers.
// - A write of 0x02 with select 00 starts a reload that finishes after about 10 ms.
// - A write of 0010000x with select 00 sets the clock output enable from bit 0.
// - With the enable at 1 and the pin set as output the internal clock is driven on the clock pin.
// - With the enable at 0, the default, the clock pin is released to high impedance.
// - The internal clock runs only while display, charge pump or measurement is on.
module lgcd_decoder (
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     reset,
    // Command stream
    input  wire lgcd_pkg::lgcd_cmd_t      cmd,
    // Calibration cells and clock pin
    input  wire lgcd_pkg::lgcd_cal_t      cal_cells,
    input  wire logic                     osc_in,
    input  wire logic                     clk_pin_is_output,
    // Status and settings
    output lgcd_pkg::lgcd_settings_t      settings,
    output lgcd_pkg::lgcd_cal_t           cal,
    output logic                          reset_status_flag,
    output logic                          clock_output_enable,
    output logic                          reload_busy,
    output logic                          int_clk_run,
    output logic                          clk_pin_out,
    output logic                          clk_pin_oe
);
    typedef enum logic {ST_IDLE, ST_RELOAD} lgcd_state_t;

    lgcd_pkg::lgcd_settings_t stage_d, stage_q, live_d, live_q, dflt;
    lgcd_pkg::lgcd_cal_t      cal_d, cal_q;
    lgcd_state_t              state_d, state_q;
    logic [lgcd_pkg::RELOAD_CNT_W-1:0] cnt_d, cnt_q;
    logic                     flag_d, flag_q, coe_d, coe_q;
    logic                     busy_d, busy_q;
    logic                     is_gen, do_reset, do_reload;
    logic [7:0]               b;

    // --------------------------------------------------------------
    // General command decode
    // --------------------------------------------------------------
    always_comb begin
        b         = cmd.data;
        is_gen    = cmd.valid & ~cmd.rw & (cmd.rsel == lgcd_pkg::RSEL_GENERAL);
        do_reset  = is_gen & (b == lgcd_pkg::CMD_CHIP_RESET);
        do_reload = is_gen & ((b == lgcd_pkg::CMD_CAL_RELOAD) | do_reset);
        dflt = '{disp_on:      1'b0,
                 cursor_on:    1'b0,
                 blink_on:     1'b0,
                 inversion:    lgcd_pkg::INV_RESET,
                 frame_freq:   lgcd_pkg::FF_RESET,
                 pump_on:      1'b0,
                 pump_stages:  lgcd_pkg::CPC_RESET,
                 vlcd_a:       lgcd_pkg::VLCD_RESET,
                 vlcd_b:       lgcd_pkg::VLCD_RESET,
                 tc_on:        1'b0,
                 temp_filter:  1'b0,
                 temp_meas_on: 1'b0,
                 slope_a:      lgcd_pkg::SLOPE_RESET,
                 slope_b:      lgcd_pkg::SLOPE_RESET,
                 slope_c:      lgcd_pkg::SLOPE_RESET,
                 slope_d:      lgcd_pkg::SLOPE_RESET};
    end

    // --------------------------------------------------------------
    // Settings: staged by command bytes, made live on commit
    // --------------------------------------------------------------
    always_comb begin
        stage_d = stage_q;
        live_d  = live_q;
        if (cmd.valid && !cmd.rw && cmd.rsel == lgcd_pkg::RSEL_DISPLAY) begin
            if (b[7:3] == 5'h08) begin
                stage_d.inversion = b[2:0];
            end else if (b[7:5] == 3'h4) begin
                stage_d.frame_freq = b[4:0];
            end else if (b[7:3] == 5'h04) begin
                stage_d.disp_on   = b[2];
                stage_d.cursor_on = b[1];
                stage_d.blink_on  = b[0];
            end
        end
        if (cmd.valid && !cmd.rw && cmd.rsel == lgcd_pkg::RSEL_PUMP_TC) begin
            if (b[7:3] == 5'h10) begin
                stage_d.pump_on     = b[2];
                stage_d.pump_stages = b[1:0];
            end else if (b[7:5] == 3'h5) begin
                stage_d.vlcd_a[8:4] = b[4:0];
            end else if (b[7:4] == 4'h9) begin
                stage_d.vlcd_a[3:0] = b[3:0];
            end else if (b[7:5] == 3'h6) begin
                stage_d.vlcd_b[8:4] = b[4:0];
            end else if (b[7:4] == 4'he) begin
                stage_d.vlcd_b[3:0] = b[3:0];
            end else if (b[7:3] == 5'h00) begin
                stage_d.tc_on        = b[2];
                stage_d.temp_filter  = b[1];
                stage_d.temp_meas_on = b[0];
            end else if (b[7:3] == 5'h01) begin
                stage_d.slope_a = b[2:0];
            end else if (b[7:3] == 5'h02) begin
                stage_d.slope_b = b[2:0];
            end else if (b[7:3] == 5'h03) begin
                stage_d.slope_c = b[2:0];
            end else if (b[7:3] == 5'h04) begin
                stage_d.slope_d = b[2:0];
            end
        end
        // Undefined encodings fall through and change nothing
        if (is_gen && b == lgcd_pkg::CMD_COMMIT) begin
            live_d = stage_q;
        end
        if (do_reset) begin
            stage_d = dflt;
            live_d  = dflt;
        end
    end

    // --------------------------------------------------------------
    // Flag, clock output enable, calibration reload
    // --------------------------------------------------------------
    always_comb begin
        flag_d  = flag_q;
        coe_d   = coe_q;
        cal_d   = cal_q;
        state_d = state_q;
        cnt_d   = cnt_q;
        if (is_gen && b == lgcd_pkg::CMD_CLEAR_FLAG) begin
            flag_d = 1'b0;
        end
        if (is_gen && b[7:1] == lgcd_pkg::CMD_CLKOUT_HIGH) begin
            coe_d = b[0];
        end
        if (do_reset) begin
            coe_d = 1'b0;
        end
        unique case (state_q)
            ST_IDLE: begin
                if (do_reload) begin
                    state_d = ST_RELOAD;
                    cnt_d   = lgcd_pkg::RELOAD_CNT_W'(lgcd_pkg::RELOAD_CYCLES - 1);
                end
            end
            ST_RELOAD: begin
                if (cnt_q == '0) begin
                    cal_d   = cal_cells;
                    state_d = ST_IDLE;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
        endcase
        // Busy is registered so the port comes straight from a flop
        busy_d = (state_d == ST_RELOAD);
    end

    // --------------------------------------------------------------
    // Settings registers
    // --------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            stage_q <= '0;
            live_q  <= '0;
        end else begin
            stage_q <= stage_d;
            live_q  <= live_d;
        end
    end

    // --------------------------------------------------------------
    // Control registers
    // --------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cal_q   <= '0;
            flag_q  <= 1'b1;
            coe_q   <= 1'b0;
            state_q <= ST_IDLE;
            cnt_q   <= '0;
            busy_q  <= 1'b0;
        end else begin
            cal_q   <= cal_d;
            flag_q  <= flag_d;
            coe_q   <= coe_d;
            state_q <= state_d;
            cnt_q   <= cnt_d;
            busy_q  <= busy_d;
        end
    end

    // --------------------------------------------------------------
    // Outputs
    // --------------------------------------------------------------
    assign settings            = live_q;
    assign cal                 = cal_q;
    assign reset_status_flag   = flag_q;
    assign clock_output_enable = coe_q;
    assign reload_busy         = busy_q;

    // --------------------------------------------------------------
    // Clock gate
    // --------------------------------------------------------------
    // Gate sees live settings so the clock follows what the host committed
    lgcd_clock_gate u_gate (
        .clk                 (clk),
        .reset               (reset),
        .osc_in              (osc_in),
        .disp_on             (live_q.disp_on),
        .pump_on             (live_q.pump_on),
        .temp_meas_on        (live_q.temp_meas_on),
        .clock_output_enable (coe_q),
        .clk_pin_is_output   (clk_pin_is_output),
        .int_clk_run         (int_clk_run),
        .clk_pin_out         (clk_pin_out),
        .clk_pin_oe          (clk_pin_oe)
    );
endmodule : lgcd_decoder
`default_nettype wire

// *** lgcd_decoder_sva.sv ***
// Port checker for the general command decoder
`default_nettype none
module lgcd_decoder_chk (
    // Watched ports
    input wire logic                     clk,
    input wire logic                     reset,
    input wire lgcd_pkg::lgcd_cmd_t      cmd,
    input wire logic                     clk_pin_is_output,
    input wire lgcd_pkg::lgcd_settings_t settings,
    input wire lgcd_pkg::lgcd_cal_t      cal,
    input wire logic                     reset_status_flag,
    input wire logic                     clock_output_enable,
    input wire logic                     reload_busy,
    input wire logic                     int_clk_run,
    input wire logic                     clk_pin_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int RELOAD_CYCLES = lgcd_pkg::RELOAD_CYCLES;
    logic gen_w, live_w, load_w, coe_w, any_on;
    int   cnt_q, cnt_d;
    assign gen_w  = cmd.valid && !cmd.rw && cmd.rsel == lgcd_pkg::RSEL_GENERAL;
    assign live_w = gen_w && cmd.data inside {8'h00, 8'h01};
    assign load_w = gen_w && cmd.data inside {8'h01, 8'h02};
    assign coe_w  = gen_w && cmd.data[7:1] == lgcd_pkg::CMD_CLKOUT_HIGH;
    assign any_on = settings.disp_on || settings.pump_on || settings.temp_meas_on;
    // Busy span is counted: far too long for a repetition
    always_comb cnt_d = reload_busy ? cnt_q + 1 : 0;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) cnt_q <= 0;
        else cnt_q <= cnt_d;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // --------
    // Properties
    // --------
    property p_commit; $changed(settings) |-> $past(live_w); endproperty
    a_commit: assert property (p_commit) else $error("settings moved without commit");
    property p_init; gen_w && cmd.data == 8'h01 |=> settings == '0 && !clock_output_enable;
    endproperty
    a_init: assert property (p_init) else $error("chip reset left state");
    property p_clear; gen_w && cmd.data == 8'h1f |=> !reset_status_flag; endproperty
    a_clear: assert property (p_clear) else $error("flag not cleared");
    property p_flag; 1'b1 |-> !$rose(reset_status_flag); endproperty
    a_flag: assert property (p_flag) else $error("flag set by command");
    property p_coe; coe_w |=> clock_output_enable == $past(cmd.data[0]); endproperty
    a_coe: assert property (p_coe) else $error("enable not taken");
    property p_drive; clock_output_enable && clk_pin_is_output |=> clk_pin_oe; endproperty
    a_drive: assert property (p_drive) else $error("pin not driven");
    property p_hiz; !(clock_output_enable && clk_pin_is_output) |=> !clk_pin_oe; endproperty
    a_hiz: assert property (p_hiz) else $error("pin driven while off");
    property p_gate; 1'b1 |-> int_clk_run == $past(any_on); endproperty
    a_gate: assert property (p_gate) else $error("clock gate wrong");
    property p_start; load_w && !reload_busy |=> reload_busy; endproperty
    a_start: assert property (p_start) else $error("reload not started");
    property p_len; $fell(reload_busy) |-> cnt_q == RELOAD_CYCLES; endproperty
    a_len: assert property (p_len) else $error("reload length wrong");
    property p_cal; $changed(cal) |-> $fell(reload_busy); endproperty
    a_cal: assert property (p_cal) else $error("cal moved outside reload end");
    c_commit: cover property (live_w);
    c_done: cover property ($fell(reload_busy));
    c_pin: cover property (clk_pin_oe);
endmodule : lgcd_decoder_chk
`default_nettype wire

// *** lgcd_host_model.sv ***
// Host model that issues command bytes
`default_nettype none
module lgcd_host_model (
    // Clock
    input  wire logic          clk,
    // Command stream
    output var lgcd_pkg::lgcd_cmd_t cmd
);
    timeunit 1ns;
    timeprecision 1ns;
    initial cmd = '0;
    // Chip reset goes first after power-on only defined bytes are sent
    task automatic send(input logic rw, input logic [1:0] rs, input logic [7:0] d);
        @(negedge clk);
        cmd <= '{1'b1, rw, rs, d};
        @(negedge clk);
        cmd.valid <= 1'b0;
        cmd.data <= ~d; // Stale byte must not look held
    endtask : send
endmodule : lgcd_host_model
`default_nettype wire

// *** lgcd_pkg.sv ***
// Package for the general command decoder: encodings, layouts, timing
`default_nettype none
package lgcd_pkg;
    // ------------------------------------------------------------------
    // Register-select values
    // ------------------------------------------------------------------
    localparam logic [1:0] RSEL_GENERAL = 2'h0;
    localparam logic [1:0] RSEL_DISPLAY = 2'h2;
    localparam logic [1:0] RSEL_PUMP_TC = 2'h3;
    // ------------------------------------------------------------------
    // General command bytes
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_COMMIT      = 8'h00;
    localparam logic [7:0] CMD_CHIP_RESET  = 8'h01;
    localparam logic [7:0] CMD_CAL_RELOAD  = 8'h02;
    localparam logic [7:0] CMD_CLEAR_FLAG  = 8'h1f;
    localparam logic [6:0] CMD_CLKOUT_HIGH = 7'h10;
    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ          = 10_000_000;
    localparam int RELOAD_TIME_MS  = 10;
    localparam int RELOAD_CYCLES   = (CLK_HZ / 1000) * RELOAD_TIME_MS;
    localparam int RELOAD_CNT_W    = 17;
    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [2:0] INV_RESET   = 3'h0;
    localparam logic [4:0] FF_RESET    = 5'h00;
    localparam logic [8:0] VLCD_RESET  = 9'h000;
    localparam logic [1:0] CPC_RESET   = 2'h0;
    localparam logic [2:0] SLOPE_RESET = 3'h0;
    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       valid;
        logic       rw;
        logic [1:0] rsel;
        logic [7:0] data;
    } lgcd_cmd_t;

    typedef struct packed {
        logic       disp_on;
        logic       cursor_on;
        logic       blink_on;
        logic [2:0] inversion;
        logic [4:0] frame_freq;
        logic       pump_on;
        logic [1:0] pump_stages;
        logic [8:0] vlcd_a;
        logic [8:0] vlcd_b;
        logic       tc_on;
        logic       temp_filter;
        logic       temp_meas_on;
        logic [2:0] slope_a;
        logic [2:0] slope_b;
        logic [2:0] slope_c;
        logic [2:0] slope_d;
    } lgcd_settings_t;

    typedef struct packed {
        logic [8:0] vlcd_trim;
        logic [4:0] freq_trim;
        logic [7:0] temp_trim;
    } lgcd_cal_t;
endpackage : lgcd_pkg
`default_nettype wire

// *** testbench.sv ***
// Testbench for the general command decoder
`default_nettype none
bind lgcd_decoder lgcd_decoder_chk i_lgcd_decoder_chk (.clk(clk), .reset(reset), .cmd(cmd),
    .clk_pin_is_output(clk_pin_is_output), .settings(settings), .cal(cal),
    .reset_status_flag(reset_status_flag), .clock_output_enable(clock_output_enable),
    .reload_busy(reload_busy), .int_clk_run(int_clk_run), .clk_pin_oe(clk_pin_oe));
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    lgcd_pkg::lgcd_cmd_t      cmd;
    lgcd_pkg::lgcd_cal_t      cal_cells, cal;
    lgcd_pkg::lgcd_settings_t settings;
    logic clk = 1'b0, reset = 1'b1, osc_in = 1'b0, clk_pin_is_output = 1'b1;
    logic reset_status_flag, clock_output_enable, reload_busy, int_clk_run, clk_pin_out;
    logic clk_pin_oe;
    int   errors = 0, total_checks = 0, n;
    lgcd_host_model i_lgcd_host_model (.clk(clk), .cmd(cmd));
    lgcd_decoder i_lgcd_decoder (.clk(clk), .reset(reset), .cmd(cmd), .cal_cells(cal_cells),
        .osc_in(osc_in), .clk_pin_is_output(clk_pin_is_output), .settings(settings), .cal(cal),
        .reset_status_flag(reset_status_flag), .clock_output_enable(clock_output_enable),
        .reload_busy(reload_busy), .int_clk_run(int_clk_run), .clk_pin_out(clk_pin_out),
        .clk_pin_oe(clk_pin_oe));
    always #50 clk = ~clk;
    task automatic wr(input logic rw, input logic [1:0] rs, input logic [7:0] d);
        i_lgcd_host_model.send(rw, rs, d);
    endtask : wr
    task automatic tick();
        @(negedge clk);
    endtask : tick
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish
    // Watchdog: one reload plus some hundred cycles of traffic
    initial begin
        repeat (101500) @(posedge clk);
        errors++;
        tally_and_finish();
    end
    initial begin
        cal_cells = '{9'h1a5, 5'h13, 8'h6c};
        repeat (20) tick();
        reset = 1'b0;
        `CHK("flag", 1'b1, reset_status_flag)
        `CHK("oe", 1'b0, clk_pin_oe)
        wr(0, 0, 8'h01);
        wr(0, 0, 8'h02);
        n = 2;
        while (reload_busy === 1'b1 && n < 100100) begin
            n++;
            tick();
        end
        `CHK("busy_len", lgcd_pkg::RELOAD_CYCLES, n)
        `CHK("cal", cal_cells, cal)
        $display("test reload done");
        wr(1, 0, 8'h1f);
        `CHK("flag_rd", 1'b1, reset_status_flag)
        wr(0, 0, 8'h1f);
        `CHK("flag_clr", 1'b0, reset_status_flag)
        $display("test flag done");
        wr(0, 2, 8'h27);
        wr(0, 2, 8'h45);
        wr(0, 2, 8'h93);
        `CHK("staged", 1'b0, settings.disp_on)
        wr(0, 0, 8'h00);
        `CHK("dcb", 3'h7, {settings.disp_on, settings.cursor_on, settings.blink_on})
        `CHK("inv", 3'h5, settings.inversion)
        `CHK("ff", 5'h13, settings.frame_freq)
        tick();
        `CHK("run_disp", 1'b1, int_clk_run)
        $display("test commit done");
        wr(0, 0, 8'h21);
        `CHK("coe", 1'b1, clock_output_enable)
        osc_in = 1'b1;
        repeat (2) tick();
        `CHK("oe_on", 1'b1, clk_pin_oe)
        `CHK("out_hi", 1'b1, clk_pin_out)
        osc_in = 1'b0;
        repeat (2) tick();
        `CHK("out_lo", 1'b0, clk_pin_out)
        clk_pin_is_output = 1'b0;
        repeat (2) tick();
        `CHK("oe_in", 1'b0, clk_pin_oe)
        clk_pin_is_output = 1'b1;
        wr(0, 0, 8'h20);
        tick();
        `CHK("oe_off", 1'b0, clk_pin_oe)
        $display("test clock pin done");
        wr(0, 2, 8'h20);
        wr(0, 3, 8'h84);
        wr(0, 0, 8'h00);
        tick();
        `CHK("run_pump", 1'b1, int_clk_run)
        wr(0, 3, 8'h80);
        wr(0, 0, 8'h00);
        tick();
        `CHK("run_off", 1'b0, int_clk_run)
        wr(0, 3, 8'h01);
        wr(0, 0, 8'h00);
        tick();
        `CHK("run_temp", 1'b1, int_clk_run)
        $display("test gate done");
        wr(0, 3, 8'h83);
        wr(0, 3, 8'hb5);
        wr(0, 3, 8'h9a);
        wr(0, 3, 8'hc3);
        wr(0, 3, 8'he7);
        wr(0, 3, 8'h06);
        wr(0, 3, 8'h0d);
        wr(0, 3, 8'h16);
        wr(0, 3, 8'h1b);
        wr(0, 3, 8'h22);
        `CHK("vlcd_staged", 9'h000, settings.vlcd_a)
        wr(0, 0, 8'h00);
        `CHK("pump", 3'h3, {settings.pump_on, settings.pump_stages})
        `CHK("vlcd_a", 9'h15a, settings.vlcd_a)
        `CHK("vlcd_b", 9'h037, settings.vlcd_b)
        `CHK("temp", 3'h6, {settings.tc_on, settings.temp_filter, settings.temp_meas_on})
        `CHK("slopes", 12'hb9a, {settings.slope_a, settings.slope_b, settings.slope_c,
            settings.slope_d})
        $display("test settings done");
        wr(0, 0, 8'h21);
        wr(0, 0, 8'h01);
        `CHK("init_set", '0, settings)
        `CHK("init_coe", 1'b0, clock_output_enable)
        `CHK("init_busy", 1'b1, reload_busy)
        $display("test chip reset done");
        tally_and_finish();
    end
endmodule : testbench
`undef CHK
`default_nettype wire
